// [hw/mcu_glue_cfg.svh]
// register offsets, reset values, decode tables and cycle counts
// assumes a 16-bit apb byte address and a 25 MHz core clock
`ifndef MCU_GLUE_CFG_SVH
`define MCU_GLUE_CFG_SVH
`define OFF_CTRL   16'h0000
`define OFF_DDR    16'h0004
`define OFF_DOUT   16'h0008
`define OFF_PIN    16'h000c
`define OFF_STAT   16'h0010
`define IDX_OPT    16'h1fdf
`define OFF_OPT    (`IDX_OPT * 16'h0004)
`define CTRL_RST   5'h10
`define OPT_RST    2'h0
`define D_MASK     8'hbf
`define POR_CYC    12'hfe0
`define FAIL_CYC   12'h010
`define CMON_CYC   12'h040
`define RAM_B0     9'h0b0
`define RAM_B1     9'h0d0
`define RAM_B2     9'h110
`define RAM_B3     9'h130
`define PROM_B0    13'h1e40
`define PROM_B1    13'h1e10
`define PROM_B2    13'h1de0
`define PROM_B3    13'h1db0
`endif

// [hw/mcu_glue_pkg.sv]
// types shared by the pin, interrupt and memory option glue
// assumes the constants of mcu_glue_cfg.svh
package mcu_glue_pkg;
	typedef struct packed {
		logic [7:0] d;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} io_t;
	typedef struct packed {
		logic ibit;
		logic tx_en;
		logic rx_en;
		logic spi_en;
		logic level;
	} ctrl_t;
	typedef enum logic [1:0] {
		RS_POR  = 2'b00,
		RS_PIN  = 2'b01,
		RS_RUN  = 2'b10,
		RS_FAIL = 2'b11
	} rst_state_t;
endpackage

// [hw/mcu_pin_glue.sv]
// chip glue: irq latch, reset pin, monitors, port d mux, ram option
// assumes an apb master on core_clk_i and synchronous pin inputs
// Overview of operation
// - irq sensitivity: falling edge, or edge plus low
// - combined mode latches on edge or low level
// - irq fall sets pending latch after sync delay
// - service at instruction end if pending, unmasked
// - reset pin active low, input resets device
// - open-drain pull of reset pin on failure
// - clock monitor resets on stopped or slow clock
// - illegal opcode raises non-maskable interrupt
// - processor clock is oscillator divided by two
// - ports one to three per-pin direction
// - reset makes all fourth port lines inputs
// - spi enable hands port four bits 2-5
// - receiver enable uses port four bit 0
// - transmitter enable drives port four bit 1
// - two ram size bits pick memory layout
// - reset forces both ram size bits zero
// - decode ram and prom byte counts
// - any reset clears latch, sets mask
// - power-on delay, then wait for pin high
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "mcu_glue_cfg.svh"
module mcu_pin_glue (
	input  wire logic               core_clk_i,
	input  wire logic               rst_n_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [15:0]        paddr_i,
	input  wire logic [31:0]        pwdata_i,
	output logic      [31:0]        prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire logic               rst_pin_i,
	output logic                    rst_pin_o,
	output logic                    rst_pin_oe_n_o,
	output logic                    sys_rst_o,
	input  wire logic               sw_watchdog_fail_i,
	input  wire logic               osc_ref_i,
	input  wire logic               irq_n_i,
	input  wire logic               instr_done_i,
	input  wire logic               illegal_op_i,
	output logic                    irq_take_o,
	output logic                    nmi_o,
	output logic                    cpu_clk_en_o,
	input  wire mcu_glue_pkg::io_t  port_in_i,
	output mcu_glue_pkg::io_t       port_out_o,
	output mcu_glue_pkg::io_t       port_oe_n_o,
	input  wire logic [3:0]         spi_out_i,
	input  wire logic [3:0]         spi_oe_n_i,
	output logic      [3:0]         spi_in_o,
	input  wire logic               serial_tx_i,
	output logic                    serial_rx_o,
	output logic      [8:0]         ram_bytes_o,
	output logic      [12:0]        prom_bytes_o
);
	import mcu_glue_pkg::*;

	rst_state_t  rs_q, rs_d;
	logic [11:0] cnt_q, cnt_d;
	logic [11:0] cmon_q, cmon_d;
	logic        osc_p_q, drive_q, drive_d;
	logic        sys_rst_q, sys_rst_d, div_q;
	logic        fail;
	logic        reg_rst;

	// reset sequencer: power-on delay, pin wait, failure pull
	always_comb begin
		rs_d = rs_q;
		cnt_d = cnt_q;
		fail = sw_watchdog_fail_i | (cmon_q == `CMON_CYC);
		// clock monitor only judges a running device
		if (rs_q != RS_RUN || osc_ref_i != osc_p_q) begin
			cmon_d = 12'h000;
		end else if (cmon_q == `CMON_CYC) begin
			cmon_d = cmon_q;
		end else begin
			cmon_d = cmon_q + 12'h001;
		end
		unique case (rs_q)
			RS_POR: begin
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == `POR_CYC - 12'h001) begin
					cnt_d = 12'h000;
					rs_d = rst_pin_i ? RS_RUN : RS_PIN;
				end
			end
			RS_PIN: begin
				if (rst_pin_i) begin
					rs_d = RS_RUN;
				end
			end
			RS_RUN: begin
				if (fail) begin
					rs_d = RS_FAIL;
					cnt_d = 12'h000;
				end else if (!rst_pin_i) begin
					rs_d = RS_PIN;
				end
			end
			RS_FAIL: begin
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == `FAIL_CYC - 12'h001) begin
					cnt_d = 12'h000;
					rs_d = RS_PIN;
				end
			end
		endcase
		drive_d = (rs_d == RS_FAIL);
		sys_rst_d = (rs_d != RS_RUN);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rs_q <= RS_POR;
			cnt_q <= 12'h000;
			cmon_q <= 12'h000;
			osc_p_q <= 1'b0;
			drive_q <= 1'b0;
			sys_rst_q <= 1'b1;
			div_q <= 1'b0;
		end else begin
			rs_q <= rs_d;
			cnt_q <= cnt_d;
			cmon_q <= cmon_d;
			osc_p_q <= osc_ref_i;
			drive_q <= drive_d;
			sys_rst_q <= sys_rst_d;
			div_q <= ~div_q;
		end
	end

	assign reg_rst = ~rst_n_i | sys_rst_q;

	// external interrupt latch
	logic  s1_q, s2_q, s3_q;
	logic  pend_q, pend_d, take_q, take_d, nmi_q;
	logic  irq_set;
	ctrl_t ctrl_q, ctrl_d;

	always_comb begin
		// s3 high and s2 low is a synchronised falling edge
		irq_set = (s3_q & ~s2_q)
			| (ctrl_q.level & ~s2_q);
		take_d = instr_done_i & pend_q & ~ctrl_q.ibit;
		// a new request in the service cycle is kept
		pend_d = irq_set | (pend_q & ~take_d);
	end

	always_ff @(posedge core_clk_i) begin
		if (reg_rst) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			pend_q <= 1'b0;
			take_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			s1_q <= irq_n_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pend_q <= pend_d;
			take_q <= take_d;
			nmi_q <= illegal_op_i;
		end
	end

	// apb registers
	io_t         ddr_q, ddr_d, dout_q, dout_d;
	logic [1:0]  opt_q, opt_d;
	logic [31:0] rd_d, prdata_q;
	logic        hit, wr, pready_q, pslverr_q;

	always_comb begin
		ctrl_d = ctrl_q;
		ddr_d = ddr_q;
		dout_d = dout_q;
		opt_d = opt_q;
		rd_d = 32'h0000_0000;
		hit = 1'b1;
		wr = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
		unique case (paddr_i)
			`OFF_CTRL: rd_d = {27'h0, ctrl_q};
			`OFF_DDR:  rd_d = ddr_q;
			`OFF_DOUT: rd_d = dout_q;
			`OFF_PIN:  rd_d = port_in_i & {`D_MASK, 24'hff_ffff};
			`OFF_STAT: rd_d = {ram_bytes_o, 3'h0, prom_bytes_o,
				6'h0, pend_q};
			`OFF_OPT:  rd_d = {30'h0, opt_q};
			default:   hit = 1'b0;
		endcase
		if (wr) begin
			unique case (paddr_i)
				`OFF_CTRL: ctrl_d = pwdata_i[4:0];
				`OFF_DDR:  ddr_d = pwdata_i
					& {`D_MASK, 24'hff_ffff};
				`OFF_DOUT: dout_d = pwdata_i;
				`OFF_OPT:  opt_d = pwdata_i[1:0];
				default:   ;
			endcase
		end
		// entering service masks further requests, over a write
		if (take_d) begin
			ctrl_d.ibit = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reg_rst) begin
			ctrl_q <= `CTRL_RST;
			ddr_q <= '0;
			dout_q <= '0;
			opt_q <= `OPT_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ddr_q <= ddr_d;
			dout_q <= dout_d;
			opt_q <= opt_d;
			// no wait state: ready rises for the first access cycle
			pready_q <= psel_i & ~penable_i;
			if (psel_i & ~penable_i) begin
				prdata_q <= rd_d;
				pslverr_q <= ~hit;
			end
		end
	end

	// port drivers and memory decode
	io_t         out_d, oen_d, out_q, oen_q;
	logic [3:0]  spi_in_d, spi_in_q;
	logic        rx_q;
	logic [8:0]  ram_q, ram_d;
	logic [12:0] prom_q, prom_d;

	always_comb begin
		out_d = dout_q;
		oen_d = ~ddr_q;
		spi_in_d = 4'h0;
		if (ctrl_q.spi_en) begin
			out_d.d[5:2] = spi_out_i;
			oen_d.d[5:2] = spi_oe_n_i;
			spi_in_d = port_in_i.d[5:2];
		end
		if (ctrl_q.rx_en) begin
			oen_d.d[0] = 1'b1;
		end
		if (ctrl_q.tx_en) begin
			out_d.d[1] = serial_tx_i;
			oen_d.d[1] = 1'b0;
		end
		unique case (opt_q)
			2'h0: {ram_d, prom_d} = {`RAM_B0, `PROM_B0};
			2'h1: {ram_d, prom_d} = {`RAM_B1, `PROM_B1};
			2'h2: {ram_d, prom_d} = {`RAM_B2, `PROM_B2};
			2'h3: {ram_d, prom_d} = {`RAM_B3, `PROM_B3};
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reg_rst) begin
			out_q <= '0;
			oen_q <= '1;
			spi_in_q <= 4'h0;
			rx_q <= 1'b1;
			ram_q <= `RAM_B0;
			prom_q <= `PROM_B0;
		end else begin
			out_q <= out_d;
			oen_q <= oen_d;
			spi_in_q <= spi_in_d;
			// idle line level while the receiver is off
			rx_q <= ctrl_q.rx_en ? port_in_i.d[0] : 1'b1;
			ram_q <= ram_d;
			prom_q <= prom_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_n_o = ~drive_q;
	assign sys_rst_o = sys_rst_q;
	assign irq_take_o = take_q;
	assign nmi_o = nmi_q;
	assign cpu_clk_en_o = div_q;
	assign port_out_o = out_q;
	assign port_oe_n_o = oen_q;
	assign spi_in_o = spi_in_q;
	assign serial_rx_o = rx_q;
	assign ram_bytes_o = ram_q;
	assign prom_bytes_o = prom_q;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence svc_s;
		instr_done_i && pend_q && !ctrl_q.ibit && !irq_set;
	endsequence

	por_hold_a: assert property (
		rst_n_i && rs_q == RS_POR && cnt_q < `POR_CYC - 12'h001
		|=> rs_q == RS_POR && sys_rst_o
		&& cnt_q == $past(cnt_q) + 12'h001)
		else $error("power-on delay broken");
	pin_wait_a: assert property (
		rs_q == RS_POR && cnt_q == `POR_CYC - 12'h001 && !rst_pin_i
		|=> rs_q == RS_PIN && sys_rst_o)
		else $error("reset not held for low pin");
	pin_drive_a: assert property (
		rs_q == RS_RUN && sw_watchdog_fail_i
		|=> !rst_pin_oe_n_o [*8])
		else $error("reset pin not pulled on failure");
	irq_edge_a: assert property (
		!sys_rst_q && $fell(s2_q) |=> pend_q)
		else $error("falling irq not latched");
	svc_clear_a: assert property (
		svc_s |=> irq_take_o && !pend_q && ctrl_q.ibit)
		else $error("service did not clear latch");
	nmi_a: assert property (
		!sys_rst_q && illegal_op_i |=> nmi_o)
		else $error("illegal opcode without nmi");
	cpu_div_a: assert property (
		cpu_clk_en_o |=> !cpu_clk_en_o ##1 cpu_clk_en_o)
		else $error("processor clock not half rate");
	rst_clear_a: assert property (
		sys_rst_q |=> !pend_q && ctrl_q.ibit && opt_q == 2'h0
		&& ddr_q.d == 8'h00)
		else $error("reset state not forced");
	ram_dec_a: assert property (
		!sys_rst_q && opt_q == 2'h2
		|=> ram_bytes_o == `RAM_B2 && prom_bytes_o == `PROM_B2)
		else $error("memory decode wrong");
endmodule

// [sim/mcu_pin_irq_memcfg_glue_bench.sv]
// self-checking bench for the pin, interrupt and memory option glue
// assumes the design hand-over timing for apb and the irq latch
`timescale 1ns/1ps
`include "mcu_glue_cfg.svh"
module mcu_pin_irq_memcfg_glue_bench;
	import mcu_glue_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic        wdf = 0, stop = 0, osc = 0, instr = 0, ill = 0;
	logic        pull = 0, irq_req = 0, t, er;
	logic        pready, pslverr, pin_lvl, pin_o, pin_oe_n, sys_rst;
	logic        irq_n, take, nmi, cken, rx, c;
	logic        tx = 1;
	logic [3:0]  spi_o = 4'h0, spi_oen = 4'hf;
	logic [31:0] pin_in = '0;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0]  spi_in;
	logic [8:0]  ramb;
	logic [12:0] promb;
	io_t         pout, poe_n;
	int          bad_count = 0, comparisons = 0;

	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (!stop) osc <= ~osc;
	end

	mcu_pin_glue mcu_pin_glue_inst (.core_clk_i(clk), .rst_n_i(rst_n),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rst_pin_i(pin_lvl), .rst_pin_o(pin_o),
		.rst_pin_oe_n_o(pin_oe_n), .sys_rst_o(sys_rst),
		.sw_watchdog_fail_i(wdf), .osc_ref_i(osc), .irq_n_i(irq_n),
		.instr_done_i(instr), .illegal_op_i(ill), .irq_take_o(take),
		.nmi_o(nmi), .cpu_clk_en_o(cken), .port_in_i(pin_in),
		.port_out_o(pout), .port_oe_n_o(poe_n), .spi_out_i(spi_o),
		.spi_oe_n_i(spi_oen), .spi_in_o(spi_in), .serial_tx_i(tx),
		.serial_rx_o(rx), .ram_bytes_o(ramb), .prom_bytes_o(promb));

	rst_irq_partner rst_irq_partner_inst (.clk_i(clk), .pull_i(pull),
		.irq_req_i(irq_req), .dev_oe_n_i(pin_oe_n), .pin_lvl_o(pin_lvl),
		.irq_n_o(irq_n));

	task give_verdict;
		$display("comparisons %0d errors %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task tmo;
		bad_count++;
		$display("[ERR] %0t wait ran out", $time);
		give_verdict();
	endtask

	// one transfer, then an idle edge so no signal is driven twice at once
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) tmo();
		rd = prdata;
		er = pslverr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask

	task wait_rel;
		int n;
		for (n = 0; n < 6000 && sys_rst !== 1'b0; n++) @(posedge clk);
		if (n == 6000) tmo();
	endtask

	task done_take(output logic got);
		int n;
		got = 0;
		instr <= 1;
		@(posedge clk);
		instr <= 0;
		for (n = 0; n < 4; n++) begin
			@(posedge clk);
			if (take === 1'b1) got = 1;
		end
	endtask

	task reset_defaults;
		chk(ramb, 9'h0b0);
		chk(promb, 13'h1e40);
		chk(poe_n, 32'hffffffff);
		chk(rx, 1);
		apb(0, `OFF_CTRL, 0);
		chk(rd[4], 1);
	endtask

	task mem_decode;
		logic [8:0]  rb [4];
		logic [12:0] pb [4];
		rb = '{9'h0b0, 9'h0d0, 9'h110, 9'h130};
		pb = '{13'h1e40, 13'h1e10, 13'h1de0, 13'h1db0};
		for (int i = 0; i < 4; i++) begin
			apb(1, `OFF_OPT, i);
			repeat (2) @(posedge clk);
			chk(ramb, rb[i]);
			chk(promb, pb[i]);
			apb(0, `OFF_OPT, 0);
			chk(rd[1:0], i);
		end
		apb(0, 16'h0020, 0);
		chk(er, 1);
		apb(0, `OFF_STAT, 0);
		chk(rd[31:23], 9'h130);
	endtask

	task irq_flow;
		apb(1, `OFF_CTRL, 0);
		irq_req <= 1;
		repeat (8) @(posedge clk);
		apb(0, `OFF_STAT, 0);
		chk(rd[0], 1);
		done_take(t);
		chk(t, 1);
		apb(0, `OFF_STAT, 0);
		chk(rd[0], 0);
		apb(1, `OFF_CTRL, 32'h11);
		repeat (6) @(posedge clk);
		apb(0, `OFF_STAT, 0);
		chk(rd[0], 1);
		done_take(t);
		chk(t, 0);
		apb(1, `OFF_CTRL, 32'h1);
		done_take(t);
		chk(t, 1);
		irq_req <= 0;
		apb(1, `OFF_CTRL, 32'h10);
	endtask

	task nmi_clk;
		ill <= 1;
		@(posedge clk);
		ill <= 0;
		@(posedge clk);
		chk(nmi, 1);
		c = cken;
		@(posedge clk);
		chk(nmi, 0);
		chk(cken, !c);
	endtask

	// pins and the serial engines carry distinct patterns so a wrong
	// mux leg shows up as a wrong bit, except spi out and tx enable, which match the dout and ddr settings
	task port_mux;
		apb(1, `OFF_DDR, 32'hffff_ffff);
		apb(1, `OFF_DOUT, 32'h5a3c_a5c3);
		apb(0, `OFF_DDR, 0);
		chk(rd, 32'hbfff_ffff);
		pin_in <= 32'h68c3_a51e;
		spi_o <= 4'h6;
		spi_oen <= 4'h9;
		tx <= 1'b0;
		apb(1, `OFF_CTRL, 32'h1e);
		repeat (2) @(posedge clk);
		chk(pout, 32'h583c_a5c3);
		chk(poe_n, 32'h6500_0000);
		chk(spi_in, 4'ha);
		chk(rx, 0);
		apb(0, `OFF_PIN, 0);
		chk(rd, 32'h28c3_a51e);
		apb(1, `OFF_CTRL, 32'h10);
		repeat (2) @(posedge clk);
		chk(pout, 32'h5a3c_a5c3);
		chk(poe_n, 32'h4000_0000);
		chk(spi_in, 0);
		chk(rx, 1);
	endtask

	task pin_reset;
		pull <= 1;
		repeat (4) @(posedge clk);
		chk(sys_rst, 1);
		pull <= 0;
		wait_rel();
		chk(ramb, 9'h0b0);
		chk(poe_n, 32'hffffffff);
		apb(0, `OFF_CTRL, 0);
		chk(rd[4], 1);
	endtask

	// k 0: watchdog failure, k 1: oscillator reference stops
	task fail_run(input int k);
		int n;
		if (k == 0) wdf <= 1;
		else stop <= 1;
		for (n = 0; n < 200 && pin_lvl !== 1'b0; n++) @(posedge clk);
		if (n == 200) tmo();
		chk(pin_oe_n, 0);
		chk(sys_rst, 1);
		wdf <= 0;
		stop <= 0;
		wait_rel();
	endtask

	// power-on with the pin still held low past the delay
	task por_pin;
		rst_n <= 0;
		pull <= 1;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		repeat (4100) @(posedge clk);
		chk(sys_rst, 1);
		chk(pin_oe_n, 1);
		pull <= 0;
		wait_rel();
		chk(sys_rst, 0);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		wait_rel();
		reset_defaults();
		mem_decode();
		irq_flow();
		nmi_clk();
		port_mux();
		pin_reset();
		fail_run(0);
		fail_run(1);
		por_pin();
		give_verdict();
	end
endmodule

// [sim/rst_irq_partner.sv]
// far-side model: external interrupt source and reset supervisor
// assumes the bench commands it and the reset pin has a pull-up
`timescale 1ns/1ps
module rst_irq_partner (
	input  wire logic clk_i,
	input  wire logic pull_i,
	input  wire logic irq_req_i,
	input  wire logic dev_oe_n_i,
	output logic      pin_lvl_o,
	output logic      irq_n_o
);
	// wired-or reset pin: anyone pulling wins, released floats high
	assign pin_lvl_o = !(pull_i || !dev_oe_n_i);
	// irq line also has a pull-up, so released means high; the
	// source is a board flop on the same clock, not a free edge
	always_ff @(posedge clk_i) begin
		irq_n_o <= !irq_req_i;
	end
endmodule
